// File: hw/operand_address_resolver.sv
// Resolves operand address and destination, and keeps the pointer pairs.
`timescale 1ns/1ns
`include "resolver_defines.svh"
module operand_address_resolver (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Decoded instruction from the decode stage
    input wire logic instr_valid,
    input wire resolver_pkg::addr_mode_t addr_mode,
    input wire resolver_pkg::dest_kind_t dest_kind,
    input wire logic [7:0] literal_addr,
    input wire logic [13:0] long_addr,
    input wire logic direct_mode_bit,
    input wire logic result_sink_bit,
    input wire logic [1:0] ptr_sel,
    input wire logic [7:0] ptr_offset,
    input wire logic [5:0] bank_pointer,
    // Result write-back from the execute stage (SFR space)
    input wire logic result_we,
    input wire logic [13:0] result_addr,
    input wire logic [7:0] result_data,
    // Resolved operand
    output logic op_valid,
    output logic [13:0] op_addr,
    output logic dest_is_acc,
    output logic dest_is_reg,
    output logic [13:0] dest_addr,
    // Pointer register read-out
    output logic [13:0] ptr0_value,
    output logic [13:0] ptr1_value,
    output logic [13:0] ptr2_value
);
    import resolver_pkg::*;

    typedef struct packed {
        logic op_valid;
        logic [13:0] op_addr;
        logic dest_is_acc;
        logic dest_is_reg;
        logic [13:0] dest_addr;
    } res_state_t;

    res_state_t state_r;
    res_state_t state_nxt;
    logic [3*14-1:0] ptr_all;
    logic [13:0] ptr_cur;
    logic [13:0] ptr_mod;
    logic ptr_upd_en;
    logic [1:0] ptr_upd_sel;
    logic [13:0] ptr_upd_value;
    logic ptr_wr_en;
    logic [1:0] ptr_wr_sel;
    logic [13:0] ptr_wr_value;
    logic [13:0] ind_addr;
    logic [13:0] direct_addr;
    logic [13:0] ptr_low_addr [3];
    logic [13:0] ptr_high_addr [3];
    logic is_ind;

    assign ptr_low_addr[0] = `PTR0_LOW_ADDR;
    assign ptr_low_addr[1] = `PTR1_LOW_ADDR;
    assign ptr_low_addr[2] = `PTR2_LOW_ADDR;
    assign ptr_high_addr[0] = `PTR0_HIGH_ADDR;
    assign ptr_high_addr[1] = `PTR1_HIGH_ADDR;
    assign ptr_high_addr[2] = `PTR2_HIGH_ADDR;

    // The pointer in use; an out-of-range selector reads as pointer 0.
    always_comb begin
        ptr_cur = ptr_all[13:0];
        if (ptr_sel < 2'd3) begin
            ptr_cur = ptr_all[ptr_sel*14 +: 14];
        end
    end

    assign is_ind = (addr_mode == MODE_IND_PLAIN) || (addr_mode == MODE_IND_POSTINC)
        || (addr_mode == MODE_IND_POSTDEC) || (addr_mode == MODE_IND_PREINC)
        || (addr_mode == MODE_IND_OFFSET);

    // Direct address: banked or access-bank mapped literal.
    always_comb begin
        if (direct_mode_bit) begin
            direct_addr = {bank_pointer, literal_addr};
        end else if (literal_addr < `ACCESS_SPLIT) begin
            direct_addr = {`ACCESS_LOW_BANK, literal_addr};
        end else begin
            direct_addr = {`ACCESS_HIGH_BANK, literal_addr};
        end
    end

    // Indirect address and pointer update; pre-increment addresses the new value.
    always_comb begin
        ind_addr = ptr_cur;
        ptr_mod = ptr_cur;
        unique case (addr_mode)
            MODE_IND_POSTINC: ptr_mod = ptr_cur + 14'h0001;
            MODE_IND_POSTDEC: ptr_mod = ptr_cur - 14'h0001;
            MODE_IND_PREINC: begin
                ptr_mod = ptr_cur + 14'h0001;
                ind_addr = ptr_mod;
            end
            MODE_IND_OFFSET: ind_addr = ptr_cur + {6'h00, ptr_offset};
            MODE_DIRECT, MODE_LONG, MODE_IND_PLAIN: ptr_mod = ptr_cur;
            default: ptr_mod = ptr_cur;
        endcase
    end

    // Auto-update has its own port, so a byte write to another pointer in the
    // same cycle cannot swallow it; on the same pointer the byte write wins.
    always_comb begin
        ptr_upd_en = 1'b0;
        ptr_upd_sel = 2'd0;
        ptr_upd_value = ptr_mod;
        if (instr_valid && is_ind && addr_mode != MODE_IND_PLAIN
                && addr_mode != MODE_IND_OFFSET && ptr_sel < 2'd3) begin
            ptr_upd_en = 1'b1;
            ptr_upd_sel = ptr_sel;
        end
    end

    // Pointer byte writes from the execute stage.
    always_comb begin
        ptr_wr_en = 1'b0;
        ptr_wr_sel = 2'd0;
        ptr_wr_value = 14'h0000;
        for (int i = 0; i < 3; i++) begin
            if (result_we && result_addr == ptr_low_addr[i]) begin
                ptr_wr_en = 1'b1;
                ptr_wr_sel = 2'(i);
                ptr_wr_value = {ptr_all[i*14+8 +: 6], result_data};
            end else if (result_we && result_addr == ptr_high_addr[i]) begin
                ptr_wr_en = 1'b1;
                ptr_wr_sel = 2'(i);
                ptr_wr_value = {result_data[5:0], ptr_all[i*14 +: 8]};
            end
        end
    end

    pointer_bank u_pointer_bank (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wr_en(ptr_wr_en),
        .wr_sel(ptr_wr_sel),
        .wr_value(ptr_wr_value),
        .upd_en(ptr_upd_en),
        .upd_sel(ptr_upd_sel),
        .upd_value(ptr_upd_value),
        .ptr_all(ptr_all)
    );

    // Operand and destination resolution, registered one cycle.
    always_comb begin
        state_nxt = state_r;
        state_nxt.op_valid = instr_valid;
        if (instr_valid) begin
            if (addr_mode == MODE_LONG) begin
                state_nxt.op_addr = long_addr;
            end else if (is_ind) begin
                state_nxt.op_addr = ind_addr;
            end else begin
                state_nxt.op_addr = direct_addr;
            end
            state_nxt.dest_addr = state_nxt.op_addr;
            unique case (dest_kind)
                DEST_SINK_BIT: begin
                    state_nxt.dest_is_reg = result_sink_bit;
                    state_nxt.dest_is_acc = !result_sink_bit;
                end
                DEST_IMPLICIT_TARGET: begin
                    state_nxt.dest_is_reg = 1'b1;
                    state_nxt.dest_is_acc = 1'b0;
                end
                DEST_IMPLICIT_ACC: begin
                    state_nxt.dest_is_reg = 1'b0;
                    state_nxt.dest_is_acc = 1'b1;
                end
                DEST_NONE: begin
                    state_nxt.dest_is_reg = 1'b0;
                    state_nxt.dest_is_acc = 1'b0;
                end
            endcase
        end else begin
            state_nxt.dest_is_reg = 1'b0;
            state_nxt.dest_is_acc = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign op_valid = state_r.op_valid;
    assign op_addr = state_r.op_addr;
    assign dest_is_acc = state_r.dest_is_acc;
    assign dest_is_reg = state_r.dest_is_reg;
    assign dest_addr = state_r.dest_addr;
    assign ptr0_value = ptr_all[13:0];
    assign ptr1_value = ptr_all[27:14];
    assign ptr2_value = ptr_all[41:28];

    // Checks.
    property p_direct_banked;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && addr_mode == MODE_DIRECT && direct_mode_bit)
            |=> op_valid && op_addr == {$past(bank_pointer), $past(literal_addr)};
    endproperty
    a_direct_banked: assert property (p_direct_banked)
        else $error("banked direct address wrong");

    property p_direct_access;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && addr_mode == MODE_DIRECT && !direct_mode_bit)
            |=> op_addr[7:0] == $past(literal_addr)
            && (op_addr[13:8] == `ACCESS_LOW_BANK || op_addr[13:8] == `ACCESS_HIGH_BANK);
    endproperty
    a_direct_access: assert property (p_direct_access)
        else $error("access bank address wrong");

    property p_long;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && addr_mode == MODE_LONG) |=> op_addr == $past(long_addr);
    endproperty
    a_long: assert property (p_long)
        else $error("long address not used");

    property p_sink_reg;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && dest_kind == DEST_SINK_BIT && result_sink_bit)
            |=> dest_is_reg && !dest_is_acc && dest_addr == op_addr;
    endproperty
    a_sink_reg: assert property (p_sink_reg)
        else $error("sink one not to register");

    property p_sink_acc;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && dest_kind == DEST_SINK_BIT && !result_sink_bit)
            |=> dest_is_acc && !dest_is_reg;
    endproperty
    a_sink_acc: assert property (p_sink_acc)
        else $error("sink zero not to accumulator");

    property p_implicit;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && dest_kind == DEST_IMPLICIT_ACC) |=> dest_is_acc && !dest_is_reg;
    endproperty
    a_implicit: assert property (p_implicit)
        else $error("implicit destination wrong");

    property p_ind_addr;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && addr_mode == MODE_IND_PLAIN && ptr_sel < 2'd3)
            |=> op_addr == ($past(ptr_sel) == 2'd0 ? $past(ptr0_value)
            : $past(ptr_sel) == 2'd1 ? $past(ptr1_value) : $past(ptr2_value));
    endproperty
    a_ind_addr: assert property (p_ind_addr)
        else $error("indirect address not pointer");

    sequence s_postinc_access;
        instr_valid && addr_mode == MODE_IND_POSTINC && ptr_sel == 2'd0 && !result_we;
    endsequence
    property p_postinc;
        @(posedge sys_clk) disable iff (!reset_n)
        s_postinc_access |=> op_addr == $past(ptr0_value)
            && ptr0_value == $past(ptr0_value) + 14'h0001;
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post increment order wrong");

    property p_high_unused;
        @(posedge sys_clk) disable iff (!reset_n)
        (result_we && result_addr == `PTR1_HIGH_ADDR && !instr_valid)
            |=> ptr1_value[13:8] == $past(result_data[5:0])
            && ptr1_value[7:0] == $past(ptr1_value[7:0]);
    endproperty
    a_high_unused: assert property (p_high_unused)
        else $error("pointer high write wrong");

    property p_access_low;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && addr_mode == MODE_DIRECT && !direct_mode_bit
            && literal_addr < `ACCESS_SPLIT) |=> op_addr[13:8] == `ACCESS_LOW_BANK;
    endproperty
    a_access_low: assert property (p_access_low)
        else $error("low access bank not selected");

    property p_access_high;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && addr_mode == MODE_DIRECT && !direct_mode_bit
            && literal_addr >= `ACCESS_SPLIT) |=> op_addr[13:8] == `ACCESS_HIGH_BANK;
    endproperty
    a_access_high: assert property (p_access_high)
        else $error("high access bank not selected");

    property p_implicit_target;
        @(posedge sys_clk) disable iff (!reset_n)
        (instr_valid && dest_kind == DEST_IMPLICIT_TARGET)
            |=> dest_is_reg && !dest_is_acc && dest_addr == op_addr;
    endproperty
    a_implicit_target: assert property (p_implicit_target)
        else $error("implicit target destination wrong");

    sequence s_postdec_access;
        instr_valid && addr_mode == MODE_IND_POSTDEC && ptr_sel == 2'd1 && !result_we;
    endsequence
    property p_postdec;
        @(posedge sys_clk) disable iff (!reset_n)
        s_postdec_access |=> op_addr == $past(ptr1_value)
            && ptr1_value == $past(ptr1_value) - 14'h0001;
    endproperty
    a_postdec: assert property (p_postdec)
        else $error("post decrement wrong");

    sequence s_preinc_access;
        instr_valid && addr_mode == MODE_IND_PREINC && ptr_sel == 2'd2 && !result_we;
    endsequence
    property p_preinc;
        @(posedge sys_clk) disable iff (!reset_n)
        s_preinc_access |=> op_addr == $past(ptr2_value) + 14'h0001
            && ptr2_value == $past(ptr2_value) + 14'h0001;
    endproperty
    a_preinc: assert property (p_preinc)
        else $error("pre increment wrong");

    sequence s_offset_access;
        instr_valid && addr_mode == MODE_IND_OFFSET && ptr_sel == 2'd2 && !result_we;
    endsequence
    property p_offset;
        @(posedge sys_clk) disable iff (!reset_n)
        s_offset_access |=> op_addr == $past(ptr2_value) + {6'h00, $past(ptr_offset)}
            && ptr2_value == $past(ptr2_value);
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset access wrong");

    property p_low_write;
        @(posedge sys_clk) disable iff (!reset_n)
        (result_we && result_addr == `PTR0_LOW_ADDR && !instr_valid)
            |=> ptr0_value[7:0] == $past(result_data)
            && ptr0_value[13:8] == $past(ptr0_value[13:8]);
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("pointer low write wrong");

    // A byte write to another pointer must not swallow the auto-update.
    sequence s_postinc_with_sfr;
        instr_valid && addr_mode == MODE_IND_POSTINC && ptr_sel == 2'd0
            && result_we && result_addr == `PTR1_LOW_ADDR;
    endsequence
    property p_postinc_sfr;
        @(posedge sys_clk) disable iff (!reset_n)
        s_postinc_with_sfr |=> ptr0_value == $past(ptr0_value) + 14'h0001
            && ptr1_value[7:0] == $past(result_data);
    endproperty
    a_postinc_sfr: assert property (p_postinc_sfr)
        else $error("auto update lost to pointer write");
endmodule : operand_address_resolver

// File: hw/resolver_defines.svh
// Constants for the operand address resolver and its pointer registers.
// Operation
// - The low instruction byte is the 8-bit direct operand address.
// - Direct mode bit one: bank pointer joined with the literal gives 14 bits.
// - Direct mode bit zero: bank pointer ignored, literal maps into access bank.
// - Long move carries a full 14-bit address; bank pointer ignored.
// - Result sink bit one: result written back to the source register.
// - Result sink bit zero: result goes to accumulator, source untouched.
// - Without a sink bit the opcode fixes destination: target or accumulator.
// - Three pointer pairs of 8-bit high and low hold 14 bits; two bits unused.
// - A 14-bit pointer reaches all data memory linearly without banking.
// - Pointer registers sit in special-function space, readable and writable.
// - Indirect operands are virtual; they access memory at their pointer.
// - Indirect variants can post-increment, post-decrement or offset the pointer.
// - Indirect addresses use the pointer only; bank pointer and mode bit ignored.
`ifndef RESOLVER_DEFINES_SVH
`define RESOLVER_DEFINES_SVH
`define ADDR_W 14
`define BANK_W 6
`define PTR_COUNT 3
// Access bank split: literals below this go to the lowest bank, others to the top one.
`define ACCESS_SPLIT 8'h60
`define ACCESS_LOW_BANK 6'h00
`define ACCESS_HIGH_BANK 6'h3f
// Special-function addresses of the pointer registers (low, high, in pairs).
`define PTR0_LOW_ADDR 14'h3fe9
`define PTR0_HIGH_ADDR 14'h3fea
`define PTR1_LOW_ADDR 14'h3fe1
`define PTR1_HIGH_ADDR 14'h3fe2
`define PTR2_LOW_ADDR 14'h3fd9
`define PTR2_HIGH_ADDR 14'h3fda
`define PTR_RESET 14'h0000
`endif

// File: hw/resolver_pkg.sv
// Types shared by the operand address resolver.
package resolver_pkg;
    typedef enum logic [2:0] {
        MODE_DIRECT,
        MODE_LONG,
        MODE_IND_PLAIN,
        MODE_IND_POSTINC,
        MODE_IND_POSTDEC,
        MODE_IND_PREINC,
        MODE_IND_OFFSET
    } addr_mode_t;
    typedef enum logic [1:0] {
        DEST_SINK_BIT,
        DEST_IMPLICIT_TARGET,
        DEST_IMPLICIT_ACC,
        DEST_NONE
    } dest_kind_t;
endpackage : resolver_pkg

// File: hw/pointer_bank.sv
// Storage for the three 14-bit pointer pairs with registered read data.
`timescale 1ns/1ns
`include "resolver_defines.svh"
module pointer_bank (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Write port, one pointer per cycle
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [13:0] wr_value,
    // Auto-update port from indirect accesses
    input wire logic upd_en,
    input wire logic [1:0] upd_sel,
    input wire logic [13:0] upd_value,
    // Full registered view of all pointers
    output logic [3*14-1:0] ptr_all
);
    import resolver_pkg::*;
    typedef struct packed {
        logic [3*14-1:0] ptr;
    } bank_state_t;
    bank_state_t state_r;
    bank_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        if (upd_en && upd_sel < 2'd3) begin
            state_nxt.ptr[upd_sel*14 +: 14] = upd_value;
        end
        // The byte write lands last, so it wins when both hit one pointer.
        if (wr_en && wr_sel < 2'd3) begin
            state_nxt.ptr[wr_sel*14 +: 14] = wr_value;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= {`PTR_COUNT{`PTR_RESET}};
        end else begin
            state_r <= state_nxt;
        end
    end
    assign ptr_all = state_r.ptr;
endmodule : pointer_bank

// File: tb/data_ram_model.sv
// Data memory model standing at the resolver's far side.
`timescale 1ns/1ns
module data_ram_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Resolved operand from the resolver
    input wire logic op_valid,
    input wire logic [13:0] op_addr,
    input wire logic dest_is_reg,
    input wire logic [7:0] wr_data,
    // Address of the most recent access
    output logic [13:0] last_addr,
    // Byte now held at that address, to see write-backs land
    output logic [7:0] rd_data
);
    // One flat array, so a 14-bit address reaches every byte with no banking.
    logic [7:0] mem [0:16383];
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_addr <= 14'h0000;
        end else if (op_valid) begin
            last_addr <= op_addr;
            if (dest_is_reg) begin
                mem[op_addr] <= wr_data;
            end
        end
    end
    assign rd_data = mem[last_addr];
endmodule : data_ram_model

// File: tb/operand_address_resolver_tb.sv
// Self-checking bench for the operand address resolver.
`timescale 1ns/1ns
`include "resolver_defines.svh"
module operand_address_resolver_tb;
    import resolver_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    addr_mode_t addr_mode = MODE_DIRECT;
    dest_kind_t dest_kind = DEST_SINK_BIT;
    logic [7:0] literal_addr = 8'h00;
    logic [13:0] long_addr = 14'h0000;
    logic direct_mode_bit = 1'b0;
    logic result_sink_bit = 1'b0;
    logic [1:0] ptr_sel = 2'h0;
    logic [7:0] ptr_offset = 8'h00;
    logic [5:0] bank_pointer = 6'h00;
    logic result_we = 1'b0;
    logic [13:0] result_addr = 14'h0000;
    logic [7:0] result_data = 8'h00;
    logic op_valid, dest_is_acc, dest_is_reg;
    logic [13:0] op_addr, dest_addr, ptr0_value, ptr1_value, ptr2_value, ram_addr;
    logic [7:0] ram_data;
    int errors = 0;
    int n_tests = 0;

    operand_address_resolver dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .instr_valid(instr_valid), .addr_mode(addr_mode), .dest_kind(dest_kind),
        .literal_addr(literal_addr), .long_addr(long_addr),
        .direct_mode_bit(direct_mode_bit), .result_sink_bit(result_sink_bit),
        .ptr_sel(ptr_sel), .ptr_offset(ptr_offset), .bank_pointer(bank_pointer),
        .result_we(result_we), .result_addr(result_addr), .result_data(result_data),
        .op_valid(op_valid), .op_addr(op_addr), .dest_is_acc(dest_is_acc),
        .dest_is_reg(dest_is_reg), .dest_addr(dest_addr), .ptr0_value(ptr0_value),
        .ptr1_value(ptr1_value), .ptr2_value(ptr2_value));

    data_ram_model ram (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_addr(op_addr), .dest_is_reg(dest_is_reg), .wr_data(8'h5a),
        .last_addr(ram_addr), .rd_data(ram_data));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task check(input logic [13:0] got, input logic [13:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Drives one decoded instruction for a single cycle, then sees the answer.
    task issue(input addr_mode_t m, input dest_kind_t d, input logic [7:0] lit,
               input logic dmb, input logic rsb, input logic [1:0] sel,
               input logic [5:0] bank);
        @(negedge sys_clk);
        addr_mode = m;
        dest_kind = d;
        literal_addr = lit;
        direct_mode_bit = dmb;
        result_sink_bit = rsb;
        ptr_sel = sel;
        bank_pointer = bank;
        instr_valid = 1'b1;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        check(14'(op_valid), 14'h1);
    endtask : issue

    task sfr_wr(input logic [13:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        result_addr = a;
        result_data = v;
        result_we = 1'b1;
        @(negedge sys_clk);
        result_we = 1'b0;
    endtask : sfr_wr

    task t_reset;
        check(ptr0_value, `PTR_RESET);
        check(ptr2_value, `PTR_RESET);
        check(14'(op_valid), 14'h0);
        $display("test reset done");
    endtask : t_reset

    task t_direct;
        issue(MODE_DIRECT, DEST_SINK_BIT, 8'h34, 1'b1, 1'b1, 2'h0, 6'h15);
        check(op_addr, 14'h1534);
        check(14'(dest_is_reg), 14'h1);
        check(dest_addr, 14'h1534);
        issue(MODE_DIRECT, DEST_SINK_BIT, 8'h5f, 1'b0, 1'b0, 2'h0, 6'h15);
        check(op_addr, 14'h005f);
        check({12'h0, dest_is_acc, dest_is_reg}, 14'h2);
        issue(MODE_DIRECT, DEST_IMPLICIT_TARGET, 8'h60, 1'b0, 1'b0, 2'h0, 6'h15);
        check(op_addr, 14'h3f60);
        check({12'h0, dest_is_acc, dest_is_reg}, 14'h1);
        issue(MODE_DIRECT, DEST_IMPLICIT_ACC, 8'hff, 1'b1, 1'b1, 2'h0, 6'h3f);
        check(op_addr, 14'h3fff);
        check({12'h0, dest_is_acc, dest_is_reg}, 14'h2);
        $display("test direct done");
    endtask : t_direct

    task t_long;
        long_addr = 14'h2abc;
        issue(MODE_LONG, DEST_NONE, 8'h11, 1'b1, 1'b0, 2'h0, 6'h3f);
        check(op_addr, 14'h2abc);
        check({12'h0, dest_is_acc, dest_is_reg}, 14'h0);
        $display("test long done");
    endtask : t_long

    task t_pointers;
        sfr_wr(`PTR0_LOW_ADDR, 8'hff);
        sfr_wr(`PTR0_HIGH_ADDR, 8'hc1);
        check(ptr0_value, 14'h01ff);
        issue(MODE_IND_POSTINC, DEST_SINK_BIT, 8'h00, 1'b1, 1'b1, 2'h0, 6'h2a);
        check(op_addr, 14'h01ff);
        check(ptr0_value, 14'h0200);
        @(negedge sys_clk);
        check(ram_addr, 14'h01ff);
        check({6'h00, ram_data}, 14'h005a);
        sfr_wr(`PTR1_HIGH_ADDR, 8'h01);
        issue(MODE_IND_POSTDEC, DEST_SINK_BIT, 8'h00, 1'b0, 1'b0, 2'h1, 6'h00);
        check(op_addr, 14'h0100);
        check(ptr1_value, 14'h00ff);
        sfr_wr(`PTR2_LOW_ADDR, 8'h10);
        issue(MODE_IND_PREINC, DEST_SINK_BIT, 8'h00, 1'b0, 1'b0, 2'h2, 6'h00);
        check(op_addr, 14'h0011);
        ptr_offset = 8'h20;
        issue(MODE_IND_OFFSET, DEST_SINK_BIT, 8'h00, 1'b1, 1'b0, 2'h2, 6'h05);
        check(op_addr, 14'h0031);
        check(ptr2_value, 14'h0011);
        sfr_wr(`PTR2_HIGH_ADDR, 8'h3a);
        issue(MODE_IND_PLAIN, DEST_SINK_BIT, 8'h00, 1'b1, 1'b0, 2'h2, 6'h01);
        check(op_addr, 14'h3a11);
        check(ptr2_value, 14'h3a11);
        result_addr = `PTR1_LOW_ADDR;
        result_data = 8'h44;
        result_we = 1'b1;
        issue(MODE_IND_POSTINC, DEST_SINK_BIT, 8'h00, 1'b0, 1'b1, 2'h0, 6'h00);
        result_we = 1'b0;
        check(op_addr, 14'h0200);
        check(ptr0_value, 14'h0201);
        check(ptr1_value, 14'h0044);
        $display("test pointers done");
    endtask : t_pointers

    task end_sim;
        $display("comparisons=%0d mismatches=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // The tests need well under a hundred cycles; this cuts a hang short.
    initial begin
        #4000;
        errors++;
        end_sim;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        t_reset;
        t_direct;
        t_long;
        t_pointers;
        end_sim;
    end
endmodule : operand_address_resolver_tb
